// *** rtl/sll_status_top.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// status led and light level logic
// ----------------------------------------------------------------------------
// Behaviour
// - green when value within alert band bounds
// - yellow when value lies outside alert band but inside measuring range
// - steady red outside measuring range
// - blinking red on lost sensor link
// - source select register, tvoc after reset
// - brightness 0 to 100 percent, 10 steps
// - measured lux readable in input register
// - active and standby thresholds are writable
// - standby state when lux below standby
// - active state when lux above active
// - low intensity state between both thresholds
// - tvoc reads zero during fifteen minute warmup
// - termination resistor follows its enable register
// - exactly one indicator lit after power up
module sll_status_top #(
    parameter int unsigned SEC_CYCLES  = sll_pkg::SEC_CYCLES,
    parameter int unsigned WARMUP_SECS = sll_pkg::WARMUP_SECS,
    parameter int unsigned SLOT_CYCLES = sll_pkg::SLOT_CYCLES
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_sys_rst,
    // measured quantities from the sensing logic
    input  wire logic [15:0]      i_tvoc_ppb,
    input  wire logic [15:0]      i_temp_val,
    input  wire logic [15:0]      i_rh_val,
    input  wire logic [15:0]      i_lux_val,
    input  wire logic             i_sensor_link_lost,
    // bounds per source, index 0 tvoc, 1 temperature, 2 humidity
    input  wire logic [2:0][15:0] i_alert_lo,
    input  wire logic [2:0][15:0] i_alert_hi,
    input  wire logic [2:0][15:0] i_range_lo,
    input  wire logic [2:0][15:0] i_range_hi,
    // register access from the modbus slave
    input  wire logic             i_reg_req,
    input  wire logic             i_reg_write,
    input  wire logic             i_reg_input_space,
    input  wire logic [15:0]      i_reg_addr,
    input  wire logic [15:0]      i_reg_wdata,
    output logic                  o_reg_ack,
    output logic                  o_reg_exc,
    output logic [15:0]           o_reg_rdata,
    // outputs
    output logic [15:0]           o_tvoc_ppb,
    output logic                  o_warming_up,
    output logic                  o_line_termination_resistor,
    output logic                  o_led_green,
    output logic                  o_led_yellow,
    output logic                  o_led_red
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    sll_led_if led ();

    logic [15:0]           term_en_q;
    logic [15:0]           light_act_q;
    logic [15:0]           light_stby_q;
    logic [15:0]           src_sel_q;
    logic [15:0]           bright_q;
    logic [15:0]           lux_q;
    sll_pkg::sll_light_t   light_st_q;
    sll_pkg::sll_light_t   light_st_d;
    logic [25:0]           sec_cnt_q;
    logic                  sec_tick_q;
    logic [15:0]           warm_secs_q;
    sll_pkg::sll_warm_t    warm_st_q;
    logic [15:0]           tvoc_eff;
    sll_pkg::sll_src_t     src;
    logic [1:0]            src_idx;
    logic [15:0]           sel_val;
    sll_pkg::sll_colour_t  colour_q;
    sll_pkg::sll_colour_t  colour_d;
    logic                  red_blink_q;
    logic                  blink_on_q;
    logic [15:0]           bright_pct;
    logic [3:0]            level_q;
    logic                  hold_hit;
    logic                  in_hit;
    logic [15:0]           rd_data;

    // ------------------------------------------------------------------------
    // second enable and warm-up sequence
    // ------------------------------------------------------------------------

    // one-cycle pulse each second, shared by warm-up and blink
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst || sec_cnt_q == 26'(SEC_CYCLES - 1))
            sec_cnt_q <= 26'h0000000;
        else
            sec_cnt_q <= sec_cnt_q + 26'h0000001;
        sec_tick_q <= !i_sys_rst && (sec_cnt_q == 26'(SEC_CYCLES - 1));
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            warm_st_q   <= sll_pkg::SLL_WS_WARM;
            warm_secs_q <= 16'h0000;
        end
        else
        begin
            case (warm_st_q)
                sll_pkg::SLL_WS_WARM:
                begin
                    if (warm_secs_q >= 16'(WARMUP_SECS))
                        warm_st_q <= sll_pkg::SLL_WS_RUN;
                    else if (sec_tick_q)
                        warm_secs_q <= warm_secs_q + 16'h0001;
                end
                sll_pkg::SLL_WS_RUN: warm_st_q <= sll_pkg::SLL_WS_RUN; // stays until reset
                default:             warm_st_q <= sll_pkg::SLL_WS_WARM;
            endcase
        end
    end

    assign tvoc_eff = (warm_st_q == sll_pkg::SLL_WS_RUN) ? i_tvoc_ppb : 16'h0000;

    // published tvoc and warm-up flag, registered
    always_ff @(posedge i_core_clk)
    begin
        o_tvoc_ppb   <= i_sys_rst ? 16'h0000 : tvoc_eff;
        o_warming_up <= i_sys_rst || (warm_st_q != sll_pkg::SLL_WS_RUN);
    end

    // ------------------------------------------------------------------------
    // holding registers
    // ------------------------------------------------------------------------
    assign hold_hit = (i_reg_addr == sll_pkg::ADDR_TERM_EN)
                   || (i_reg_addr == sll_pkg::ADDR_LIGHT_ACT)
                   || (i_reg_addr == sll_pkg::ADDR_LIGHT_STBY)
                   || (i_reg_addr == sll_pkg::ADDR_SRC_SEL)
                   || (i_reg_addr == sll_pkg::ADDR_BRIGHT);
    assign in_hit   = (i_reg_addr == sll_pkg::ADDR_LUX)
                   || (i_reg_addr == sll_pkg::ADDR_LIGHT_ST);

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            term_en_q    <= sll_pkg::RST_TERM_EN;
            light_act_q  <= sll_pkg::RST_LIGHT_ACT;
            light_stby_q <= sll_pkg::RST_LIGHT_STBY;
            src_sel_q    <= sll_pkg::RST_SRC_SEL;
            bright_q     <= sll_pkg::RST_BRIGHT;
        end
        else if (i_reg_req && i_reg_write && !i_reg_input_space)
        begin
            case (i_reg_addr)
                sll_pkg::ADDR_TERM_EN:    term_en_q    <= i_reg_wdata;
                sll_pkg::ADDR_LIGHT_ACT:  light_act_q  <= i_reg_wdata;
                sll_pkg::ADDR_LIGHT_STBY: light_stby_q <= i_reg_wdata;
                sll_pkg::ADDR_SRC_SEL:    src_sel_q    <= i_reg_wdata;
                sll_pkg::ADDR_BRIGHT:     bright_q     <= i_reg_wdata;
                default:                  term_en_q    <= term_en_q;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            o_line_termination_resistor <= 1'b0;
        else
            o_line_termination_resistor <= term_en_q[sll_pkg::TERM_EN_BIT];
    end

    // ------------------------------------------------------------------------
    // ambient light classification
    // ------------------------------------------------------------------------

    // lux sample for the input register
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            lux_q <= 16'h0000;
        else
            lux_q <= i_lux_val;
    end

    // equal to a threshold counts as low intensity; if the thresholds are
    // swapped by software, standby wins over active
    always_comb
    begin
        light_st_d = sll_pkg::SLL_LS_LOW;
        if (lux_q < light_stby_q)
            light_st_d = sll_pkg::SLL_LS_STANDBY;
        else if (lux_q > light_act_q)
            light_st_d = sll_pkg::SLL_LS_ACTIVE;
        else
            light_st_d = sll_pkg::SLL_LS_LOW;
    end

    // registered light state, one cycle behind the lux sample
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            light_st_q <= sll_pkg::SLL_LS_STANDBY;
        else
            light_st_q <= light_st_d;
    end

    // ------------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------------

    // read data is a full word, unused bits zero
    always_comb
    begin
        if (i_reg_input_space)
        begin
            case (i_reg_addr)
                sll_pkg::ADDR_LUX:      rd_data = lux_q;
                sll_pkg::ADDR_LIGHT_ST: rd_data = {14'h0000, light_st_q};
                default:                rd_data = 16'h0000;
            endcase
        end
        else
        begin
            case (i_reg_addr)
                sll_pkg::ADDR_TERM_EN:    rd_data = term_en_q;
                sll_pkg::ADDR_LIGHT_ACT:  rd_data = light_act_q;
                sll_pkg::ADDR_LIGHT_STBY: rd_data = light_stby_q;
                sll_pkg::ADDR_SRC_SEL:    rd_data = src_sel_q;
                sll_pkg::ADDR_BRIGHT:     rd_data = bright_q;
                default:                  rd_data = 16'h0000;
            endcase
        end
    end

    // answer one cycle after the request; writes to input space are refused
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_reg_ack   <= 1'b0;
            o_reg_exc   <= 1'b0;
            o_reg_rdata <= 16'h0000;
        end
        else
        begin
            o_reg_ack   <= i_reg_req;
            o_reg_exc   <= i_reg_req && (i_reg_input_space ? (i_reg_write || !in_hit) : !hold_hit);
            o_reg_rdata <= (i_reg_req && !i_reg_write) ? rd_data : 16'h0000;
        end
    end

    // ------------------------------------------------------------------------
    // indicator selection
    // ------------------------------------------------------------------------

    // source decode, unknown codes fall back to tvoc
    always_comb
    begin
        case (src_sel_q[1:0])
            2'h1:    src = sll_pkg::SLL_SRC_TEMP;
            2'h2:    src = sll_pkg::SLL_SRC_RH;
            default: src = sll_pkg::SLL_SRC_TVOC;
        endcase
        if (src_sel_q[15:2] != 14'h0000)
            src = sll_pkg::SLL_SRC_TVOC;
    end

    assign src_idx = src;

    // value mux, tvoc as published so warm-up shows zero
    always_comb
    begin
        case (src)
            sll_pkg::SLL_SRC_TEMP: sel_val = i_temp_val;
            sll_pkg::SLL_SRC_RH:   sel_val = i_rh_val;
            default:               sel_val = tvoc_eff;
        endcase
    end

    // red over yellow over green, exactly one colour
    always_comb
    begin
        colour_d = sll_pkg::SLL_COL_GREEN;
        if (i_sensor_link_lost
            || !sll_pkg::sll_in_band(sel_val, i_range_lo[src_idx], i_range_hi[src_idx]))
            colour_d = sll_pkg::SLL_COL_RED;
        else if (!sll_pkg::sll_in_band(sel_val, i_alert_lo[src_idx], i_alert_hi[src_idx]))
            colour_d = sll_pkg::SLL_COL_YELLOW;
        else
            colour_d = sll_pkg::SLL_COL_GREEN;
    end

    // one colour chosen from the first cycle after reset
    always_ff @(posedge i_core_clk)
    begin
        colour_q    <= i_sys_rst ? sll_pkg::SLL_COL_GREEN : colour_d;
        // lost link marks red as blinking
        red_blink_q <= !i_sys_rst && i_sensor_link_lost;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            blink_on_q <= 1'b1;
        else if (sec_tick_q)
            blink_on_q <= !blink_on_q;
    end

    // percent clamped to 100 and cut to whole tenths
    assign bright_pct = (bright_q > sll_pkg::BRIGHT_MAX_PCT) ? sll_pkg::BRIGHT_MAX_PCT
                                                             : bright_q;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            level_q <= 4'ha;
        else
            level_q <= 4'(bright_pct / sll_pkg::BRIGHT_STEP_PCT);
    end

    assign led.colour    = colour_q;
    assign led.red_blink = red_blink_q;
    assign led.blink_on  = blink_on_q;
    assign led.level     = level_q;

    // ------------------------------------------------------------------------
    // led driver
    // ------------------------------------------------------------------------
    sll_led_drv #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_led_drv (
        .i_core_clk   (i_core_clk),
        .i_sys_rst    (i_sys_rst),
        .led          (led.drv),
        .o_led_green  (o_led_green),
        .o_led_yellow (o_led_yellow),
        .o_led_red    (o_led_red)
    );

endmodule : sll_status_top

// *** include/sll_pkg.sv ***
// ----------------------------------------------------------------------------
// shared constants and types of the status led and light level block
// ----------------------------------------------------------------------------
package sll_pkg;

    // ------------------------------------------------------------------------
    // register map, 16-bit word addresses
    // ------------------------------------------------------------------------
    localparam logic [15:0] ADDR_TERM_EN    = 16'h0009; // holding
    localparam logic [15:0] ADDR_LIGHT_ACT  = 16'h0023; // holding
    localparam logic [15:0] ADDR_LIGHT_STBY = 16'h0024; // holding
    localparam logic [15:0] ADDR_LUX        = 16'h0029; // input
    localparam logic [15:0] ADDR_LIGHT_ST   = 16'h002a; // input
    localparam logic [15:0] ADDR_SRC_SEL    = 16'h004f; // holding
    localparam logic [15:0] ADDR_BRIGHT     = 16'h0050; // holding

    // ------------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------------
    localparam int          TERM_EN_BIT     = 0;
    localparam logic [15:0] RST_TERM_EN     = 16'h0000;
    localparam logic [15:0] RST_LIGHT_ACT   = 16'h012c;
    localparam logic [15:0] RST_LIGHT_STBY  = 16'h0032;
    localparam logic [15:0] RST_SRC_SEL     = 16'h0000;
    localparam logic [15:0] RST_BRIGHT      = 16'h0064;

    // ------------------------------------------------------------------------
    // brightness scale
    // ------------------------------------------------------------------------
    localparam logic [15:0] BRIGHT_MAX_PCT  = 16'h0064; // 100 percent
    localparam logic [15:0] BRIGHT_STEP_PCT = 16'h000a; // 10 percent
    localparam logic [3:0]  PWM_STEPS       = 4'ha;     // slots per pwm period

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned WARMUP_MIN      = 15;
    localparam int unsigned WARMUP_SECS     = WARMUP_MIN * 60;
    localparam int unsigned SEC_CYCLES      = CLK_HZ;
    localparam int unsigned PWM_HZ          = 1000;
    localparam int unsigned SLOT_CYCLES     = CLK_HZ / (PWM_HZ * 10);

    // ------------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SLL_SRC_TVOC = 2'h0,
        SLL_SRC_TEMP = 2'h1,
        SLL_SRC_RH   = 2'h2
    } sll_src_t;

    typedef enum logic [1:0]
    {
        SLL_LS_STANDBY = 2'h0,
        SLL_LS_LOW     = 2'h1,
        SLL_LS_ACTIVE  = 2'h2
    } sll_light_t;

    typedef enum logic [1:0]
    {
        SLL_COL_GREEN  = 2'h0,
        SLL_COL_YELLOW = 2'h1,
        SLL_COL_RED    = 2'h2
    } sll_colour_t;

    typedef enum logic [1:0]
    {
        SLL_WS_WARM = 2'h0,
        SLL_WS_RUN  = 2'h1
    } sll_warm_t;

    // inclusive band test, used for the alert band and the measuring range
    function automatic logic sll_in_band(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
        sll_in_band = (v >= lo) && (v <= hi);
    endfunction : sll_in_band

endpackage : sll_pkg

// *** include/sll_led_if.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// indicator request from the status logic to the led driver
// ----------------------------------------------------------------------------
interface sll_led_if;
    sll_pkg::sll_colour_t colour;    // the one colour to show
    logic                 red_blink; // red shown as blinking
    logic                 blink_on;  // blink phase
    logic [3:0]           level;     // brightness in tenths

    modport ctrl (output colour, output red_blink, output blink_on, output level);
    modport drv  (input colour, input red_blink, input blink_on, input level);
endinterface : sll_led_if

// *** rtl/sll_led_drv.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// led driver: one colour, pwm brightness in tenths, blink gating
// ----------------------------------------------------------------------------
module sll_led_drv #(
    parameter int unsigned SLOT_CYCLES = sll_pkg::SLOT_CYCLES
) (
    input  wire logic  i_core_clk,
    input  wire logic  i_sys_rst,
    sll_led_if.drv     led,
    output logic       o_led_green,
    output logic       o_led_yellow,
    output logic       o_led_red
);

    logic [15:0] slot_cnt_q;
    logic [3:0]  slot_idx_q;
    logic        pwm_on;

    // slot divider, a one-cycle enable steps the pwm slot index
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            slot_cnt_q <= 16'h0000;
            slot_idx_q <= 4'h0;
        end
        else if (slot_cnt_q == 16'(SLOT_CYCLES - 1))
        begin
            slot_cnt_q <= 16'h0000;
            slot_idx_q <= (slot_idx_q == sll_pkg::PWM_STEPS - 4'h1) ? 4'h0 : slot_idx_q + 4'h1;
        end
        else
            slot_cnt_q <= slot_cnt_q + 16'h0001;
    end

    assign pwm_on = (slot_idx_q < led.level);

    // one colour at a time; red blink gated by the blink phase
    always_ff @(posedge i_core_clk)
    begin
        o_led_green  <= !i_sys_rst && pwm_on && (led.colour == sll_pkg::SLL_COL_GREEN);
        o_led_yellow <= !i_sys_rst && pwm_on && (led.colour == sll_pkg::SLL_COL_YELLOW);
        o_led_red    <= !i_sys_rst && pwm_on && (led.colour == sll_pkg::SLL_COL_RED)
                        && (!led.red_blink || led.blink_on);
    end

endmodule : sll_led_drv

// *** test/sll_master_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// register master stand-in
// ------------------------------------------
module sll_master_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_ack,
    input  wire logic        i_exc,
    input  wire logic [15:0] i_rdata,
    output logic             o_req,
    output logic             o_write,
    output logic             o_space,
    output logic [15:0]      o_addr,
    output logic [15:0]      o_wdata
);
    // idle bus before the first transfer
    initial
        {o_req, o_write, o_space, o_addr, o_wdata} = 35'h0;

    task automatic xfer(input logic w, input logic s, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic e);
        @(posedge i_core_clk);
        #1;
        o_req   = 1'b1;
        o_write = w;
        o_space = s;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_core_clk);
        #1;
        o_req   = 1'b0;
        o_addr  = ~a; // released lines must not keep the old value
        o_wdata = ~d;
        q       = i_rdata;
        e       = i_ack ? i_exc : 1'bx; // a missing answer never matches
    endtask : xfer
endmodule : sll_master_model

// *** test/sll_status_assertions.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// port checks of the status block
// ------------------------------------------
module sll_status_assertions (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_reg_req,
    input wire logic        i_reg_write,
    input wire logic        i_reg_input_space,
    input wire logic        o_reg_ack,
    input wire logic        o_reg_exc,
    input wire logic [15:0] o_reg_rdata,
    input wire logic [15:0] i_tvoc_ppb,
    input wire logic [15:0] o_tvoc_ppb,
    input wire logic        o_warming_up,
    input wire logic        i_sensor_link_lost,
    input wire logic        o_led_green,
    input wire logic        o_led_yellow,
    input wire logic        o_led_red
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    ack_one_a: assert property (i_reg_req |=> o_reg_ack)
        else $error("no answer to request");
    ack_only_a: assert property (!i_reg_req |=> !o_reg_ack)
        else $error("answer without request");
    exc_ro_a: assert property (i_reg_req && i_reg_write && i_reg_input_space |=> o_reg_exc)
        else $error("input register write accepted");
    rdata_idle_a: assert property (!o_reg_ack |-> o_reg_rdata == 16'h0000)
        else $error("read word outside answer");
    one_led_a: assert property ($onehot0({o_led_green, o_led_yellow, o_led_red}))
        else $error("two indicators lit");
    warm_zero_a: assert property (o_warming_up |-> o_tvoc_ppb == 16'h0000)
        else $error("tvoc not zero in warm-up");
    tvoc_pass_a: assert property (!o_warming_up && !$past(o_warming_up)
        |-> o_tvoc_ppb == $past(i_tvoc_ppb))
        else $error("tvoc not passed on");
    link_red_a: assert property ($past(i_sensor_link_lost, 2) && $past(i_sensor_link_lost)
        |-> !o_led_green && !o_led_yellow)
        else $error("lost link not shown red");
    cover property (o_reg_ack && o_reg_exc);
    cover property ($fell(o_warming_up));
    cover property (i_sensor_link_lost && o_led_red);
endmodule : sll_status_assertions

// *** test/test_sll_status_top.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// self-checking bench of the status block
// ------------------------------------------
module test_sll_status_top;
    typedef struct {logic [15:0] src; logic [15:0] val; logic [2:0] led;} sll_row_t;
    logic             i_core_clk, i_sys_rst, link, req, wr, sp, ack, exc, warm, term, g, y, r, e;
    logic [15:0]      tvoc, temp, rh, lux, addr, wdat, rdat, tout, q;
    logic [15:0]      ra [5];
    logic [15:0]      rv [5];
    logic [15:0]      lv [4] = '{16'h000f, 16'h0010, 16'h0100, 16'h0101};
    logic [15:0]      ls [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002};
    logic [2:0][15:0] alo = {3{16'h0064}}, ahi = {3{16'h01f4}};
    logic [2:0][15:0] rlo = {3{16'h000a}}, rhi = {3{16'h03e8}};
    int               errors = 0, comparisons = 0, cyc = 0, n, m;
    sll_row_t         rows [7] = '{'{16'h0000, 16'h012c, 3'h4}, '{16'h0001, 16'h0032, 3'h2},
        '{16'h0002, 16'h0005, 3'h1}, '{16'h0000, 16'h03e9, 3'h1}, '{16'h0001, 16'h01f4, 3'h4},
        '{16'h0002, 16'h0063, 3'h2}, '{16'h0003, 16'h0064, 3'h4}};

    sll_status_top #(.SEC_CYCLES(20), .WARMUP_SECS(3), .SLOT_CYCLES(4)) sll_status_top_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_tvoc_ppb(tvoc),
        .i_temp_val(temp), .i_rh_val(rh), .i_lux_val(lux), .i_sensor_link_lost(link),
        .i_alert_lo(alo), .i_alert_hi(ahi), .i_range_lo(rlo), .i_range_hi(rhi),
        .i_reg_req(req), .i_reg_write(wr), .i_reg_input_space(sp), .i_reg_addr(addr),
        .i_reg_wdata(wdat), .o_reg_ack(ack), .o_reg_exc(exc), .o_reg_rdata(rdat),
        .o_tvoc_ppb(tout), .o_warming_up(warm), .o_line_termination_resistor(term),
        .o_led_green(g), .o_led_yellow(y), .o_led_red(r));
    sll_master_model sll_master_model_i (.i_core_clk(i_core_clk), .i_ack(ack), .i_exc(exc),
        .i_rdata(rdat), .o_req(req), .o_write(wr), .o_space(sp), .o_addr(addr), .o_wdata(wdat));

    // clock and a hang ceiling well past the planned run
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask : tick
    task automatic chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
        comparisons++;
        if (got !== ex)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_word
    task automatic chk_led(input string nm, input logic [2:0] ex, input logic [2:0] got);
        comparisons++;
        if (got !== ex)
        begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", nm, ex, got);
        end
    endtask : chk_led
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // main sequence: reset, rows, then the awkward cases
    initial
    begin
        ra = '{sll_pkg::ADDR_TERM_EN, sll_pkg::ADDR_LIGHT_ACT, sll_pkg::ADDR_LIGHT_STBY,
               sll_pkg::ADDR_SRC_SEL, sll_pkg::ADDR_BRIGHT};
        rv = '{sll_pkg::RST_TERM_EN, sll_pkg::RST_LIGHT_ACT, sll_pkg::RST_LIGHT_STBY,
               sll_pkg::RST_SRC_SEL, sll_pkg::RST_BRIGHT};
        {i_sys_rst, link, tvoc, temp, rh, lux} = {2'b10, 16'h0123, 48'h0};
        tick(2);
        i_sys_rst = 1'b0;
        tick(3);
        chk_word("warm tvoc", 16'h0000, tout);
        chk_led("power-up led", 3'h1, {g, y, r});
        chk_word("term off", 16'h0000, {15'h0000, term});
        for (n = 0; n < 5; n++)
        begin
            sll_master_model_i.xfer(1'b0, 1'b0, ra[n], 16'h0000, q, e);
            chk_word("reset reg", rv[n], q);
        end
        tick(70);
        chk_word("run tvoc", 16'h0123, tout);
        chk_word("warm flag", 16'h0000, {15'h0000, warm});
        for (n = 0; n < 7; n++)
        begin
            sll_master_model_i.xfer(1'b1, 1'b0, sll_pkg::ADDR_SRC_SEL, rows[n].src, q, e);
            tvoc = (rows[n].src == 16'h0001 || rows[n].src == 16'h0002) ? 16'h0005 : rows[n].val;
            temp = (rows[n].src == 16'h0001) ? rows[n].val : 16'h0005;
            rh   = (rows[n].src == 16'h0002) ? rows[n].val : 16'h0005;
            tick(4);
            chk_led("row led", rows[n].led, {g, y, r});
        end
        // brightness 0, 50 and 100 percent over one whole pwm period
        for (n = 0; n < 3; n++)
        begin
            sll_master_model_i.xfer(1'b1, 1'b0, sll_pkg::ADDR_BRIGHT, 16'(n * 50), q, e);
            tick(3);
            m = 0;
            repeat (40)
            begin
                tick(1);
                m += int'(g);
            end
            chk_word("lit cycles", 16'(n * 20), 16'(m));
        end
        sll_master_model_i.xfer(1'b1, 1'b0, sll_pkg::ADDR_LIGHT_ACT, 16'h0100, q, e);
        sll_master_model_i.xfer(1'b1, 1'b0, sll_pkg::ADDR_LIGHT_STBY, 16'h0010, q, e);
        for (n = 0; n < 4; n++)
        begin
            lux = lv[n];
            tick(3);
            sll_master_model_i.xfer(1'b0, 1'b1, sll_pkg::ADDR_LUX, 16'h0000, q, e);
            chk_word("lux", lv[n], q);
            sll_master_model_i.xfer(1'b0, 1'b1, sll_pkg::ADDR_LIGHT_ST, 16'h0000, q, e);
            chk_word("light state", ls[n], q);
        end
        sll_master_model_i.xfer(1'b1, 1'b1, sll_pkg::ADDR_LUX, 16'h1234, q, e);
        chk_word("ro write", 16'h0001, {15'h0000, e});
        sll_master_model_i.xfer(1'b0, 1'b0, 16'h0001, 16'h0000, q, e);
        chk_word("unmapped", 16'h0001, {15'h0000, e});
        sll_master_model_i.xfer(1'b1, 1'b0, sll_pkg::ADDR_TERM_EN, 16'h0001, q, e);
        tick(1);
        chk_word("term on", 16'h0001, {15'h0000, term});
        link = 1'b1;
        m = 0;
        repeat (80)
        begin
            tick(1);
            m += int'(r);
        end
        chk_word("blink", 16'h0001, {15'h0000, m > 0 && m < 80});
        wrap_up();
    end
endmodule : test_sll_status_top

bind sll_status_top sll_status_assertions chk_i (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_reg_req(i_reg_req), .i_reg_write(i_reg_write),
    .i_reg_input_space(i_reg_input_space), .o_reg_ack(o_reg_ack), .o_reg_exc(o_reg_exc),
    .o_reg_rdata(o_reg_rdata), .i_tvoc_ppb(i_tvoc_ppb), .o_tvoc_ppb(o_tvoc_ppb),
    .o_warming_up(o_warming_up), .i_sensor_link_lost(i_sensor_link_lost),
    .o_led_green(o_led_green), .o_led_yellow(o_led_yellow), .o_led_red(o_led_red));
